// *** rtl/adcc_top.sv ***
// adcc_top: register side of a 10-bit converter behind an ahb-lite slave.
// assumes the analog core presents its code on conv_code when a conversion
// ends, and that trigger flags and interrupt inputs share clk_sys.
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module adcc_top
    import adcc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic [9:0]        conv_code,
    input  wire logic [7:1]        trig_flags,
    input  wire logic              global_irq_en,
    input  wire logic              irq_ack,
    input  wire logic [7:0]        pin_in,
    output logic      [7:0]        pin_read_q,
    output logic      [7:0]        pin_buf_off_q,
    output logic                   irq_q,
    output logic                   conv_enable_q,
    output logic                   conv_start_q,
    output logic      [4:0]        chan_sel_q
);
    if (ADDR_W < 5) begin : g_chk
        $error("adcc_top: ADDR_W too small for the register map");
    end

    // software-visible state and the result read-order lock
    logic [2:0]    div_q;
    logic          auto_q;
    logic          done_q;
    logic          ie_q;
    logic [2:0]    trig_sel_q;
    logic          lalign_q;
    logic [9:0]    res_q;
    logic          lock_q;
    // bus state
    logic          wr_pend_q;
    logic          rd_pend_q;
    logic [7:0]    addr_q;
    logic          acc_ok;
    logic [7:0]    acc_addr;
    logic [7:0]    rd_val;
    logic          wr_a;
    logic          rd_lo;
    logic          rd_hi;
    // conversion state and synchronised pins
    adcc_conv_type cv_q;
    logic [4:0]    cnt_q;
    logic [4:0]    need_q;
    logic          first_q;
    logic          tick;
    logic          conv_end;
    logic          sw_start;
    logic          trig_now;
    logic          trig_prev_q;
    logic          trig_edge;
    logic          start_req;
    logic [7:0]    pin_sync;

    // address phase qualifier
    assign acc_ok   = hsel && hready && htrans[HTRANS_ACT];
    assign acc_addr = 8'(haddr);
    assign wr_a     = wr_pend_q && (addr_q == OFF_CTRL_A);
    assign rd_lo    = rd_pend_q && !hreadyout && (addr_q == OFF_RES_LO);
    assign rd_hi    = rd_pend_q && !hreadyout && (addr_q == OFF_RES_HI);

    // writes take no wait; reads take one so earlier writes land first
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (rd_pend_q && !hreadyout) begin
                hreadyout <= 1'b1;
                rd_pend_q <= 1'b0;
                wr_pend_q <= 1'b0;
            end else begin
                wr_pend_q <= acc_ok && hwrite && (hsize == HSIZE_WORD);
                rd_pend_q <= acc_ok && !hwrite;
                hreadyout <= !(acc_ok && !hwrite);
                if (acc_ok) begin
                    addr_q <= acc_addr;
                end
            end
        end
    end

    // read mux; result view follows the live alignment bit
    always_comb begin
        rd_val = 8'h00;
        if (addr_q == OFF_CTRL_A) begin
            rd_val = {conv_enable_q, cv_q == CV_RUN, auto_q, done_q, ie_q,
                      div_q};
        end else if (addr_q == OFF_RES_LO) begin
            if (lalign_q) begin
                rd_val = {res_q[1:0], 6'h00};
            end else begin
                rd_val = res_q[7:0];
            end
        end else if (addr_q == OFF_RES_HI) begin
            if (lalign_q) begin
                rd_val = res_q[9:2];
            end else begin
                rd_val = {6'h00, res_q[9:8]};
            end
        end else if (addr_q == OFF_CTRL_B) begin
            rd_val = {5'h00, trig_sel_q};
        end else if (addr_q == OFF_PIN_DIS) begin
            rd_val = pin_buf_off_q;
        end else if (addr_q == OFF_CHAN) begin
            rd_val = {2'h0, lalign_q, chan_sel_q};
        end
    end

    // read data register, loaded in the wait cycle, held until the next read
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_pend_q && !hreadyout) begin
            hrdata <= {24'h00_0000, rd_val};
        end
    end

    // plain configuration registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            conv_enable_q <= 1'b0;
            auto_q        <= 1'b0;
            ie_q          <= 1'b0;
            div_q         <= RST_REG[2:0];
            trig_sel_q    <= RST_REG[2:0];
            pin_buf_off_q <= RST_REG;
            lalign_q      <= 1'b0;
            chan_sel_q    <= RST_REG[4:0];
        end else if (wr_pend_q) begin
            if (addr_q == OFF_CTRL_A) begin
                conv_enable_q <= hwdata[B_EN];
                auto_q        <= hwdata[B_AUTO];
                ie_q          <= hwdata[B_IE];
                div_q         <= hwdata[B_DIV +: 3];
            end else if (addr_q == OFF_CTRL_B) begin
                trig_sel_q <= hwdata[2:0];
            end else if (addr_q == OFF_PIN_DIS) begin
                pin_buf_off_q <= hwdata[7:0];
            end else if (addr_q == OFF_CHAN) begin
                lalign_q   <= hwdata[B_LALIGN];
                chan_sel_q <= hwdata[B_MUX +: 5];
            end
        end
    end

    // converter clock
    adcc_prescaler u_presc (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .run     (conv_enable_q),
        .div_sel (div_q),
        .tick_q  (tick)
    );

    // trigger signal: selected flag; free running selection yields none
    always_comb begin
        trig_now = 1'b0;
        if (trig_sel_q != TRIG_FREE) begin
            trig_now = trig_flags[trig_sel_q];
        end
    end

    // edge history runs always, so a source switch shows as an edge
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            trig_prev_q <= 1'b0;
        end else begin
            trig_prev_q <= trig_now;
        end
    end

    assign trig_edge = auto_q && trig_now && !trig_prev_q;
    assign sw_start  = wr_a && hwdata[B_START] && hwdata[B_EN];
    assign conv_end  = (cv_q == CV_RUN) && tick && (cnt_q == need_q - 5'd1);
    assign start_req = sw_start || (conv_enable_q && trig_edge) ||
                       (conv_end && auto_q && (trig_sel_q == TRIG_FREE));

    // conversion sequencer
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cv_q         <= CV_OFF;
            cnt_q        <= 5'd0;
            need_q       <= TICKS_NORMAL;
            first_q      <= 1'b0;
            conv_start_q <= 1'b0;
        end else begin
            conv_start_q <= 1'b0;
            case (cv_q)
                CV_OFF: begin
                    if (wr_a && hwdata[B_EN]) begin
                        first_q <= 1'b1;
                        cv_q    <= CV_IDLE;
                        if (sw_start) begin
                            cv_q         <= CV_RUN;
                            cnt_q        <= 5'd0;
                            need_q       <= TICKS_FIRST;
                            first_q      <= 1'b0;
                            conv_start_q <= 1'b1;
                        end
                    end
                end
                CV_IDLE: begin
                    if (!conv_enable_q || (wr_a && !hwdata[B_EN])) begin
                        cv_q <= CV_OFF;
                    end else if (start_req) begin
                        cv_q         <= CV_RUN;
                        cnt_q        <= 5'd0;
                        need_q       <= first_q ? TICKS_FIRST : TICKS_NORMAL;
                        first_q      <= 1'b0;
                        conv_start_q <= 1'b1;
                    end
                end
                CV_RUN: begin
                    if (wr_a && !hwdata[B_EN]) begin
                        cv_q <= CV_OFF;
                    end else if (conv_end) begin
                        cv_q <= CV_IDLE;
                        if (start_req) begin
                            cv_q         <= CV_RUN;
                            cnt_q        <= 5'd0;
                            need_q       <= TICKS_NORMAL;
                            conv_start_q <= 1'b1;
                        end
                    end else if (tick) begin
                        cnt_q <= cnt_q + 5'd1;
                    end
                end
                default: begin
                    cv_q <= CV_OFF;
                end
            endcase
        end
    end

    // result store and read-order lock
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            res_q  <= RST_RES;
            lock_q <= 1'b0;
        end else begin
            if (conv_end && !lock_q) begin
                res_q <= conv_code;
            end
            if (rd_lo) begin
                lock_q <= 1'b1;
            end else if (rd_hi) begin
                lock_q <= 1'b0;
            end
        end
    end

    // done flag: completion wins over vector and write-one clears
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            done_q <= 1'b0;
        end else if (conv_end) begin
            done_q <= 1'b1;
        end else if (irq_ack) begin
            done_q <= 1'b0;
        end else if (wr_a && hwdata[B_DONE]) begin
            done_q <= 1'b0;
        end
    end

    // interrupt request level
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= done_q && ie_q && global_irq_en;
        end
    end

    // pin inputs, forced low where the buffer is switched off
    adcc_sync3 #(.WIDTH(8)) u_pins (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .async_in (pin_in),
        .sync_q   (pin_sync)
    );

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pin_read_q <= 8'h00;
        end else begin
            pin_read_q <= pin_sync & ~pin_buf_off_q;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_done_sets: assert property (
        conv_end |=> done_q ##0 (cv_q != CV_RUN || conv_start_q))
        else $error("done flag not set at conversion end");
    a_irq_gate: assert property (
        irq_q |-> $past(done_q) && $past(ie_q) && $past(global_irq_en))
        else $error("interrupt raised without all enables");
    a_vec_clear: assert property (
        irq_ack && !conv_end |=> !done_q)
        else $error("vector did not clear done flag");
    a_w1c_clear: assert property (
        wr_a && hwdata[B_DONE] && !conv_end |=> !done_q)
        else $error("write one did not clear done flag");
    a_lock_hold: assert property (
        lock_q && !rd_hi |=> $stable(res_q))
        else $error("result changed while locked");
    a_no_auto: assert property (
        !auto_q && !sw_start && cv_q == CV_IDLE |=> cv_q != CV_RUN)
        else $error("conversion started with auto trigger off");
    a_abort_run: assert property (
        wr_a && !hwdata[B_EN] |=> cv_q == CV_OFF ##1 cv_q == CV_OFF)
        else $error("disable did not abort conversion");
    a_first_len: assert property (
        conv_start_q && $past(cv_q) == CV_OFF |-> need_q == TICKS_FIRST)
        else $error("first conversion length wrong");
    a_free_run: assert property (
        conv_end && auto_q && trig_sel_q == TRIG_FREE && conv_enable_q
        && !wr_a |=> cv_q == CV_RUN && conv_start_q)
        else $error("free running did not restart");
    a_pin_mask: assert property (
        (pin_read_q & $past(pin_buf_off_q)) == 8'h00)
        else $error("disabled pin read as one");
endmodule : adcc_top
`default_nettype wire

// *** rtl/adcc_pkg.sv ***
// adcc_pkg: register map, field positions and counts of the converter
// control block; shared by the top and its prescaler helper module.
//
// Operation
// - done flag sets when a conversion finishes and the result is stored
// - interrupt request only while done flag, done enable, global enable
// - done flag clears when the processor takes the conversion vector
// - writing one to the done flag clears it; zero leaves it
// - converter clock divide: codes 0,1 give 2, then 4 up to 128
// - right aligned: result 9:8 in high bits 1:0, 7:0 in low
// - left aligned: result 9:2 in high, 1:0 in low bits 7:6
// - after a low byte read, results freeze until high byte read
// - trigger source select ignored while auto triggering is off
// - auto trigger starts a conversion on a rising source flag edge
// - switching from a clear source to a set one is an edge
// - selecting free running never creates a trigger event itself
// - source codes 0..7: free run, comparator, ext0, t0 cmp, t0 ovf...
// - a set pin disable bit forces that pin's port input to zero
// - enable turns converter on; clearing aborts a running conversion
// - start bit reads one while converting; writing zero does nothing
// - first conversion after enabling takes 25 converter clocks, else 13
// - left align change alters result presentation at once
package adcc_pkg;
    // byte addresses of the word-wide registers
    localparam logic [7:0] OFF_CTRL_A  = 8'h00;
    localparam logic [7:0] OFF_RES_LO  = 8'h04;
    localparam logic [7:0] OFF_RES_HI  = 8'h08;
    localparam logic [7:0] OFF_CTRL_B  = 8'h0c;
    localparam logic [7:0] OFF_PIN_DIS = 8'h10;
    localparam logic [7:0] OFF_CHAN    = 8'h14;
    // control A fields
    localparam int B_EN    = 7;
    localparam int B_START = 6;
    localparam int B_AUTO  = 5;
    localparam int B_DONE  = 4;
    localparam int B_IE    = 3;
    localparam int B_DIV   = 0;
    // channel select register fields
    localparam int B_LALIGN = 5;
    localparam int B_MUX    = 0;
    // reset values
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [9:0] RST_RES = 10'h000;
    // converter clock counts per conversion, and the free running trigger code
    localparam logic [4:0] TICKS_NORMAL = 5'd13;
    localparam logic [4:0] TICKS_FIRST  = 5'd25;
    localparam logic [2:0] TRIG_FREE    = 3'h0;
    // ahb encodings and the conversion state type
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int         HTRANS_ACT = 1;
    typedef enum logic [1:0] {CV_OFF, CV_IDLE, CV_RUN} adcc_conv_type;
endpackage : adcc_pkg

// *** rtl/adcc_sync3.sv ***
// adcc_sync3: three-stage synchroniser for pin levels.
// assumes inputs from outside the clk_sys domain; output is a flop.
`timescale 1ns/1ps
`default_nettype none
module adcc_sync3 #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_q
);
    logic [WIDTH-1:0] ff1_q;
    logic [WIDTH-1:0] ff2_q;
    logic [WIDTH-1:0] ff3_q;

    // chain; first stage feeds only the second
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ff1_q <= '0;
            ff2_q <= '0;
            ff3_q <= '0;
        end else begin
            ff1_q <= async_in;
            ff2_q <= ff1_q;
            ff3_q <= ff2_q;
        end
    end

    // accept a bit once second and third stages agree
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sync_q <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (ff2_q[i] == ff3_q[i]) begin
                    sync_q[i] <= ff3_q[i];
                end
            end
        end
    end
endmodule : adcc_sync3
`default_nettype wire

// *** rtl/adcc_prescaler.sv ***
// adcc_prescaler: converter clock divider giving one tick per period.
// assumes run is a same-clock level; counter restarts while stopped.
`timescale 1ns/1ps
`default_nettype none
module adcc_prescaler
    import adcc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic       run,
    input  wire logic [2:0] div_sel,
    output logic            tick_q
);
    logic [6:0] cnt_q;
    logic [6:0] limit;

    // divide factor minus one; codes 0 and 1 both divide by two
    always_comb begin
        if (div_sel == 3'h0) begin
            limit = 7'h01;
        end else begin
            limit = 7'((8'h01 << div_sel) - 8'h01);
        end
    end

    // free counter with a one-cycle tick at wrap
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_q  <= 7'h00;
            tick_q <= 1'b0;
        end else if (!run) begin
            cnt_q  <= 7'h00;
            tick_q <= 1'b0;
        end else if (cnt_q >= limit) begin
            cnt_q  <= 7'h00;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 7'h01;
            tick_q <= 1'b0;
        end
    end
endmodule : adcc_prescaler
`default_nettype wire

// *** testbench/adcc_tb.sv ***
// testbench: self-checking bench for the converter control block.
// assumes adcc_top is the only ahb-lite slave and clk_sys runs at 250 MHz.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import adcc_pkg::*;
;
    logic        clk_sys       = 1'b0;
    logic        rstn          = 1'b0;
    logic        hsel          = 1'b0;
    logic [7:0]  haddr         = 8'h00;
    logic [1:0]  htrans        = 2'h0;
    logic        hwrite        = 1'b0;
    logic [2:0]  hsize         = 3'h0;
    logic [31:0] hwdata        = 32'h0;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [9:0]  conv_code     = 10'h2a5;
    logic [7:1]  trig_flags    = 7'h00;
    logic        global_irq_en = 1'b1;
    logic        irq_ack       = 1'b0;
    logic [7:0]  pin_in        = 8'h00;
    logic [2:0]  bus_size      = HSIZE_WORD;
    logic        resp_seen     = 1'b0;
    logic [7:0]  pin_read_q;
    logic [7:0]  pin_buf_off_q;
    logic        irq_q;
    logic        conv_enable_q;
    logic        conv_start_q;
    logic [4:0]  chan_sel_q;
    int          err_total     = 0;
    int          checks_done   = 0;
    int          starts        = 0;

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    // system clock, 4 ns period
    always #2 clk_sys = ~clk_sys;

    // count conversion start pulses
    always @(posedge clk_sys) if (conv_start_q === 1'b1) starts <= starts + 1;

    adcc_top dut (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .conv_code(conv_code), .trig_flags(trig_flags),
        .global_irq_en(global_irq_en), .irq_ack(irq_ack), .pin_in(pin_in),
        .pin_read_q(pin_read_q), .pin_buf_off_q(pin_buf_off_q),
        .irq_q(irq_q), .conv_enable_q(conv_enable_q),
        .conv_start_q(conv_start_q), .chan_sel_q(chan_sel_q));

    // final report and verdict
    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // compare one value against its expectation
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // settle n edges, then sit on the falling edge to sample
    task automatic see(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : see

    // one single transfer of size bus_size, waiting on ready in both phases
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        logic r;
        int   n;
        @(posedge clk_sys);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= bus_size;
        for (int p = 0; p < 2; p++) begin
            n = 0;
            do begin
                @(negedge clk_sys);
                r  = hreadyout;
                rd = hrdata;
                resp_seen = hresp;
                @(posedge clk_sys);
                n++;
            end while (r !== 1'b1 && n < 64);
            if (r !== 1'b1) begin
                err_total++;
                wrap_up();
            end
            htrans <= 2'h0;
            hwdata <= wd;
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        cmp(x, exp);
        cmp({31'h0, resp_seen}, 32'h0);
    endtask : rc

    // wait for the interrupt request, counting cycles
    task automatic wait_irq(output int n);
        logic r;
        repeat (3) @(posedge clk_sys);
        n = 3;
        do begin
            @(negedge clk_sys);
            r = irq_q;
            @(posedge clk_sys);
            n++;
        end while (r !== 1'b1 && n < 4000);
        if (r !== 1'b1) begin
            err_total++;
            wrap_up();
        end
    endtask : wait_irq

    // reset values, an ignored byte-size write and an unmapped word
    task automatic t_regs();
        rc(OFF_CTRL_A, 32'h0);
        rc(OFF_RES_LO, 32'h0);
        rc(OFF_RES_HI, 32'h0);
        rc(OFF_PIN_DIS, 32'h0);
        wr(OFF_CTRL_B, 32'h07);
        rc(OFF_CTRL_B, 32'h07);
        bus_size = 3'h0;
        wr(OFF_CTRL_B, 32'h02);
        bus_size = HSIZE_WORD;
        rc(OFF_CTRL_B, 32'h07);
        wr(8'h20, 32'hff);
        rc(8'h20, 32'h0);
    endtask : t_regs

    // conversion length for every divide code, first one long
    task automatic t_divide();
        int n;
        int f;
        int e;
        for (int c = 0; c < 8; c++) begin
            f = (c < 2) ? 2 : (1 << c);
            e = ((c == 0) ? 25 : 13) * f;
            wr(OFF_CTRL_A, 32'hd8 | 32'(c));
            wait_irq(n);
            cmp(32'(n >= e - f && n <= e + f + 8), 32'h1);
        end
    endtask : t_divide

    // right and left alignment, switched without a conversion
    task automatic t_align();
        rc(OFF_RES_LO, 32'ha5);
        rc(OFF_RES_HI, 32'h02);
        wr(OFF_CHAN, 32'h35);
        see(1);
        cmp({27'h0, chan_sel_q}, 32'h15);
        rc(OFF_RES_LO, 32'h40);
        rc(OFF_RES_HI, 32'ha9);
        wr(OFF_CHAN, 32'h00);
    endtask : t_align

    // low byte read freezes the pair until the high byte is read
    task automatic t_lock();
        int n;
        conv_code <= 10'h1c3;
        rc(OFF_RES_LO, 32'ha5);
        wr(OFF_CTRL_A, 32'hd8);
        wait_irq(n);
        rc(OFF_RES_HI, 32'h02);
        rc(OFF_RES_LO, 32'ha5);
        rc(OFF_RES_HI, 32'h02);
        wr(OFF_CTRL_A, 32'hd8);
        wait_irq(n);
        rc(OFF_RES_LO, 32'hc3);
        rc(OFF_RES_HI, 32'h01);
    endtask : t_lock

    // done flag clearing, request gating and vector acknowledge
    task automatic t_flag();
        int n;
        wr(OFF_CTRL_A, 32'h88);
        rc(OFF_CTRL_A, 32'h98);
        see(0);
        cmp({31'h0, irq_q}, 32'h1);
        @(posedge clk_sys);
        global_irq_en <= 1'b0;
        see(2);
        cmp({31'h0, irq_q}, 32'h0);
        @(posedge clk_sys);
        global_irq_en <= 1'b1;
        wr(OFF_CTRL_A, 32'h98);
        see(2);
        cmp({31'h0, irq_q}, 32'h0);
        rc(OFF_CTRL_A, 32'h88);
        wr(OFF_CTRL_A, 32'hc8);
        rc(OFF_CTRL_A, 32'hc8);
        wait_irq(n);
        irq_ack <= 1'b1;
        @(posedge clk_sys);
        irq_ack <= 1'b0;
        rc(OFF_CTRL_A, 32'h88);
    endtask : t_flag

    // raise or drop one trigger flag and count the starts it causes
    task automatic flag_try(input int i, input logic v, input int exp);
        int s;
        see(0);
        s = starts;
        @(posedge clk_sys);
        trig_flags[i] <= v;
        see(60);
        cmp(32'(starts - s), 32'(exp));
    endtask : flag_try

    // change the trigger source and count the starts it causes
    task automatic sel_try(input logic [2:0] code, input int exp);
        int s;
        see(0);
        s = starts;
        wr(OFF_CTRL_B, {29'h0, code});
        see(60);
        cmp(32'(starts - s), 32'(exp));
    endtask : sel_try

    // auto trigger, source switching, free running and abort
    task automatic t_trig();
        int s;
        wr(OFF_CTRL_B, 32'h3);
        wr(OFF_CTRL_A, 32'h88);
        flag_try(3, 1'b1, 0);
        flag_try(3, 1'b0, 0);
        wr(OFF_CTRL_A, 32'ha8);
        flag_try(3, 1'b1, 1);
        flag_try(5, 1'b1, 0);
        sel_try(3'h1, 0);
        sel_try(3'h5, 1);
        sel_try(TRIG_FREE, 0);
        s = starts;
        wr(OFF_CTRL_A, 32'he8);
        see(120);
        cmp(32'(starts - s >= 3), 32'h1);
        cmp({31'h0, conv_enable_q}, 32'h1);
        wr(OFF_CTRL_A, 32'h00);
        see(2);
        cmp({31'h0, conv_enable_q}, 32'h0);
        rc(OFF_CTRL_A, 32'h10);
    endtask : t_trig

    // digital input disable gates the pin readback
    task automatic t_pins();
        pin_in <= 8'hff;
        wr(OFF_PIN_DIS, 32'h0f);
        see(8);
        cmp({24'h0, pin_read_q}, 32'hf0);
        cmp({24'h0, pin_buf_off_q}, 32'h0f);
        rc(OFF_PIN_DIS, 32'h0f);
    endtask : t_pins

    // reset, then the scenarios in turn
    initial begin
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        t_regs();
        t_divide();
        t_align();
        t_lock();
        t_flag();
        t_trig();
        t_pins();
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
